// ### logic/vsfp_regs.vh
// Purpose: constants for the soft-start and fault sequencer
// Assumes: 100 MHz controller clock
// Notes: step time kept in ns with its cycle count derived; latch-off given in cycles
`ifndef VSFP_REGS_VH
`define VSFP_REGS_VH
`define VSFP_CLK_MHZ 100
// 50 us of 10 ns cycles, sized to the 13-bit latch-off counter
`define VSFP_OC_CYCLES 13'h1388
`define VSFP_STEP_TIME_NS 100
`define VSFP_STEP_CYCLES (`VSFP_STEP_TIME_NS * `VSFP_CLK_MHZ / 1000)
`define VSFP_DRV_SETTLE 3'h3
`define VSFP_CODE_W 8
`define VSFP_CODE_ZERO 8'h00
`define VSFP_CODE_ONE 8'h01
`define VSFP_NPH 3
`define VSFP_NSYNC 6
`define VSFP_SY_EN 0
`define VSFP_SY_DRV 1
`define VSFP_SY_ILO 2
`define VSFP_SY_IHI 3
`define VSFP_SY_UV 4
`define VSFP_SY_OV 5
`define VSFP_ST_W 3
`define VSFP_ST_IDLE 3'h0
`define VSFP_ST_MID 3'h1
`define VSFP_ST_DRV 3'h2
`define VSFP_ST_RAMP 3'h3
`define VSFP_ST_RUN 3'h4
`define VSFP_ST_OVDN 3'h5
`define VSFP_ST_OVHOLD 3'h6
`define VSFP_ST_OCOFF 3'h7
`endif

// ### logic/vsfp_sequencer.v
// Purpose: start-up, over-current, under- and over-voltage sequencing
// Assumes: comparator and pin levels arrive asynchronously, code inputs
//   and modulator pulses come from logic on clock_in
// Notes: driver enable is an open-drain style pin with readback
//
// How it works
// - phases mid, then driver enable, then ramp
// - driver pulls enable low: mid, restart
// - reference code steps from zero to target
// - phase leaves mid on its first pulse
// - current limit scales with active phases
// - lower current threshold starts latch-off timer
// - still over after 50 us: shut down
// - higher current threshold: shut down at once
// - over-current latch cleared only by enable low
// - output 300 mV under: regulator ready low
// - output 300 mV over: phases forced low
// - first overvoltage trip ramps reference to zero
// - reference zero: phases low, driver enable high
// - overvoltage latch cleared only by enable low
// - ignore overvoltage during soft-start or transition
// - second overvoltage detector active in every state but idle, over-current off and the two overvoltage states
`timescale 1ns/10ps
`include "vsfp_regs.vh"

module vsfp_sequencer
#(
  parameter [12:0] OC_LATCH_CYCLES = `VSFP_OC_CYCLES
)
(
  input wire clock_in,
  input wire srst_in,
  input wire clk_en_in,
  input wire enable_in,
  input wire driver_enable_in,
  input wire current_limit_input_low_trip_in,
  input wire current_limit_input_high_trip_in,
  input wire undervolt_trip_in,
  input wire overvolt_trip_in,
  input wire current_sense_reference_overvolt_in,
  input wire dynamic_voltage_id_transition_in,
  input wire [7:0] target_code_in,
  input wire [2:0] phase_pulse_in,
  input wire [1:0] phase_total_in,
  input wire [1:0] phase_shed_in,
  input wire shed_mode_in,
  output reg driver_enable_out,
  output reg driver_enable_oe_n_out,
  output reg [7:0] ref_code_out,
  output reg [2:0] phase_mid_out,
  output reg [2:0] phase_low_out,
  output reg regulator_ready_out,
  output reg [1:0] current_limit_phases_out,
  output reg softstart_active_out,
  output reg oc_fault_out,
  output reg ov_fault_out
);

  localparam [12:0] OC_ONE = 13'h0001;
  localparam integer STEP_CYC = `VSFP_STEP_CYCLES;
  localparam [3:0] STEP_LAST = STEP_CYC[3:0] - 4'h1;

  wire [`VSFP_NSYNC-1:0] raw_in;
  reg [`VSFP_NSYNC-1:0] sync1_q;
  reg [`VSFP_NSYNC-1:0] sync2_q;
  reg [`VSFP_ST_W-1:0] state_q;
  reg [`VSFP_ST_W-1:0] state_d;
  reg [12:0] oc_cnt_q;
  reg [3:0] step_cnt_q;
  reg [2:0] settle_q;
  reg [2:0] mid_q;
  reg [`VSFP_CODE_W-1:0] code_q;
  reg csov_s1_q;
  reg csov_s2_q;

  wire en_s = sync2_q[`VSFP_SY_EN];
  wire drv_s = sync2_q[`VSFP_SY_DRV];
  wire ilo_s = sync2_q[`VSFP_SY_ILO];
  wire ihi_s = sync2_q[`VSFP_SY_IHI];
  wire uv_s = sync2_q[`VSFP_SY_UV];
  wire ov_s = sync2_q[`VSFP_SY_OV];
  wire step_tick = (step_cnt_q == STEP_LAST);

  // states in which the power stage is live
  function live;
    input [`VSFP_ST_W-1:0] st;
    begin
      live = (st == `VSFP_ST_RAMP) || (st == `VSFP_ST_RUN);
    end
  endfunction

  assign raw_in = {overvolt_trip_in, undervolt_trip_in, current_limit_input_high_trip_in,
                   current_limit_input_low_trip_in, driver_enable_in, enable_in};

  // first stage feeds only the second
  genvar gi;
  generate
    for (gi = 0; gi < `VSFP_NSYNC; gi = gi + 1)
    begin : g_sync
      always @(posedge clock_in)
      begin
        if (srst_in)
        begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end
        else if (clk_en_in)
        begin
          sync1_q[gi] <= raw_in[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  // second detector watches the pin in every state but idle, over-current off and the two overvoltage states
  always @(posedge clock_in)
  begin
    if (srst_in)
    begin
      csov_s1_q <= 1'b0;
      csov_s2_q <= 1'b0;
    end
    else if (clk_en_in)
    begin
      csov_s1_q <= current_sense_reference_overvolt_in;
      csov_s2_q <= csov_s1_q;
    end
  end

  wire oc_timeout = ilo_s && (oc_cnt_q >= OC_LATCH_CYCLES - OC_ONE);
  // reference-relative comparator masked while ramping or moving
  wire ov_ref = ov_s && (state_q == `VSFP_ST_RUN)
                && !dynamic_voltage_id_transition_in;

  always @*
  begin
    state_d = state_q;
    case (state_q)
      `VSFP_ST_IDLE:
        if (en_s)
          state_d = `VSFP_ST_MID;
      `VSFP_ST_MID:
        state_d = `VSFP_ST_DRV;
      `VSFP_ST_DRV:
        if (settle_q == `VSFP_DRV_SETTLE)
          state_d = `VSFP_ST_RAMP;
      `VSFP_ST_RAMP:
        if (code_q >= target_code_in)
          state_d = `VSFP_ST_RUN;
      `VSFP_ST_RUN:
        if (ov_ref)
          state_d = `VSFP_ST_OVDN;
      `VSFP_ST_OVDN:
        if (code_q == `VSFP_CODE_ZERO)
          state_d = `VSFP_ST_OVHOLD;
      `VSFP_ST_OVHOLD:
        state_d = `VSFP_ST_OVHOLD;
      `VSFP_ST_OCOFF:
        state_d = `VSFP_ST_OCOFF;
      default:
        state_d = `VSFP_ST_IDLE;
    endcase
    if (live(state_q))
    begin
      if (ihi_s || oc_timeout)
        state_d = `VSFP_ST_OCOFF;
      else if (!drv_s)
        state_d = `VSFP_ST_MID;
    end
    if (csov_s2_q && (state_q != `VSFP_ST_IDLE) && (state_q != `VSFP_ST_OCOFF)
        && (state_q != `VSFP_ST_OVHOLD) && (state_q != `VSFP_ST_OVDN))
      state_d = `VSFP_ST_OVDN;
    if (!en_s)
      state_d = `VSFP_ST_IDLE;
  end

  always @(posedge clock_in)
  begin
    if (srst_in)
      state_q <= `VSFP_ST_IDLE;
    else if (clk_en_in)
      state_q <= state_d;
  end

  // driver readback is only trusted after it has had time to settle
  always @(posedge clock_in)
  begin
    if (srst_in)
      settle_q <= 3'h0;
    else if (clk_en_in)
    begin
      if (state_q != `VSFP_ST_DRV)
        settle_q <= 3'h0;
      else if (drv_s && settle_q != `VSFP_DRV_SETTLE)
        settle_q <= settle_q + 3'h1;
    end
  end

  always @(posedge clock_in)
  begin
    if (srst_in)
      step_cnt_q <= 4'h0;
    else if (clk_en_in)
    begin
      if (step_tick)
        step_cnt_q <= 4'h0;
      else
        step_cnt_q <= step_cnt_q + 4'h1;
    end
  end

  // reference steps one code per tick toward its goal in ramp and overvoltage ramp-down; in run it takes the target at once
  always @(posedge clock_in)
  begin
    if (srst_in)
      code_q <= `VSFP_CODE_ZERO;
    else if (clk_en_in)
    begin
      case (state_q)
        `VSFP_ST_RAMP:
          if (step_tick && code_q < target_code_in)
            code_q <= code_q + `VSFP_CODE_ONE;
        `VSFP_ST_RUN:
          code_q <= target_code_in;
        `VSFP_ST_OVDN:
          if (step_tick && code_q != `VSFP_CODE_ZERO)
            code_q <= code_q - `VSFP_CODE_ONE;
        `VSFP_ST_OVHOLD:
          code_q <= `VSFP_CODE_ZERO;
        default:
          code_q <= `VSFP_CODE_ZERO;
      endcase
    end
  end

  // latch-off timer resets as soon as the lower trip clears
  always @(posedge clock_in)
  begin
    if (srst_in)
      oc_cnt_q <= 13'h0000;
    else if (clk_en_in)
    begin
      if (!live(state_q) || !ilo_s)
        oc_cnt_q <= 13'h0000;
      else if (!oc_timeout)
        oc_cnt_q <= oc_cnt_q + OC_ONE;
    end
  end

  // each phase holds mid until its own first pulse
  generate
    for (gi = 0; gi < `VSFP_NPH; gi = gi + 1)
    begin : g_phase
      always @(posedge clock_in)
      begin
        if (srst_in)
          mid_q[gi] <= 1'b1;
        else if (clk_en_in)
        begin
          if (!live(state_q))
            mid_q[gi] <= 1'b1;
          else if (phase_pulse_in[gi])
            mid_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always @(posedge clock_in)
  begin
    if (srst_in)
    begin
      driver_enable_out <= 1'b0;
      driver_enable_oe_n_out <= 1'b0;
      ref_code_out <= `VSFP_CODE_ZERO;
      phase_mid_out <= {`VSFP_NPH{1'b1}};
      phase_low_out <= {`VSFP_NPH{1'b0}};
      regulator_ready_out <= 1'b0;
      current_limit_phases_out <= 2'h0;
      softstart_active_out <= 1'b0;
      oc_fault_out <= 1'b0;
      ov_fault_out <= 1'b0;
    end
    else if (clk_en_in)
    begin
      // drive high once mid is set; the driver may still pull it low
      driver_enable_out <= (state_d != `VSFP_ST_IDLE) && (state_d != `VSFP_ST_MID)
                           && (state_d != `VSFP_ST_OCOFF);
      driver_enable_oe_n_out <= 1'b0;
      // restart must not show the old target while the driver comes up
      ref_code_out <= (live(state_d) || state_d == `VSFP_ST_OVDN || state_d == `VSFP_ST_OVHOLD)
                      ? code_q : `VSFP_CODE_ZERO;
      if (state_d == `VSFP_ST_OVDN || state_d == `VSFP_ST_OVHOLD)
      begin
        phase_mid_out <= {`VSFP_NPH{1'b0}};
        phase_low_out <= {`VSFP_NPH{1'b1}};
      end
      else if (ov_ref)
      begin
        phase_mid_out <= mid_q;
        phase_low_out <= ~mid_q;
      end
      else if (live(state_d))
      begin
        phase_mid_out <= mid_q & ~phase_pulse_in;
        phase_low_out <= {`VSFP_NPH{1'b0}};
      end
      else
      begin
        phase_mid_out <= {`VSFP_NPH{1'b1}};
        phase_low_out <= {`VSFP_NPH{1'b0}};
      end
      regulator_ready_out <= (state_d == `VSFP_ST_RUN) && !uv_s;
      current_limit_phases_out <= shed_mode_in ? phase_shed_in
                                               : phase_total_in;
      softstart_active_out <= (state_d == `VSFP_ST_RAMP);
      oc_fault_out <= (state_d == `VSFP_ST_OCOFF);
      ov_fault_out <= (state_d == `VSFP_ST_OVDN) || (state_d == `VSFP_ST_OVHOLD);
    end
  end

endmodule

// ### sim/vsfp_props.sv
// Purpose: port checks for vsfp_sequencer
// Assumes: one clock, sync reset
// Notes: input sync delay taken as three edges
`timescale 1ns/10ps
module vsfp_props (
  input wire clock_in,
  input wire srst_in,
  input wire enable_in,
  input wire undervolt_trip_in,
  input wire current_sense_reference_overvolt_in,
  input wire [2:0] phase_pulse_in,
  input wire [1:0] phase_shed_in,
  input wire shed_mode_in,
  input wire driver_enable_out,
  input wire [7:0] ref_code_out,
  input wire [2:0] phase_mid_out,
  input wire [2:0] phase_low_out,
  input wire regulator_ready_out,
  input wire [1:0] current_limit_phases_out,
  input wire softstart_active_out,
  input wire oc_fault_out,
  input wire ov_fault_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (srst_in);
  drv_mid_a: assert property (
    $rose(driver_enable_out) && !ov_fault_out |-> phase_mid_out == 3'h7 && ref_code_out == 8'h00)
    else $error("driver on before mid");
  ramp_step_a: assert property (
    softstart_active_out && $past(softstart_active_out) && ref_code_out != $past(ref_code_out)
    |-> ref_code_out == $past(ref_code_out) + 8'h01) else $error("bad ramp step");
  mid_release_a: assert property (
    $fell(phase_mid_out[0]) && !ov_fault_out |-> $past(phase_pulse_in[0]))
    else $error("mid left without pulse");
  limit_shed_a: assert property (
    shed_mode_in |=> current_limit_phases_out == $past(phase_shed_in))
    else $error("limit not scaled");
  oc_latch_a: assert property (
    oc_fault_out && enable_in && $past(enable_in) && $past(enable_in, 2) |=> oc_fault_out)
    else $error("oc latch lost");
  uv_ready_a: assert property (
    undervolt_trip_in [*4] |-> !regulator_ready_out) else $error("ready kept in uv");
  ov_hold_a: assert property (
    ov_fault_out && ref_code_out == 8'h00 && $past(driver_enable_out)
    |-> phase_low_out == 3'h7 && driver_enable_out) else $error("ov hold wrong");
  current_sense_reference_ov_a: assert property (
    (current_sense_reference_overvolt_in && enable_in) [*4] ##0 driver_enable_out |=> ov_fault_out)
    else $error("current_sense_reference ov missed");
endmodule

// ### sim/vsfp_drv_model.sv
// Purpose: gate driver pulling driver enable low on low supply
// Assumes: wire is low if either side pulls it low
// Notes: pull held 8 cycles so the restart is seen
`timescale 1ns/10ps
module vsfp_drv_model (
  input wire clock_in,
  input wire low_supply_in,
  input wire drv_in,
  output wire drv_wire_out
);
  int hold = 0;
  always @(posedge clock_in)
    hold <= low_supply_in ? 8 : (hold > 0 ? hold - 1 : 0);
  assign drv_wire_out = drv_in && !low_supply_in && hold == 0;
endmodule

// ### sim/vsfp_sequencer_test.sv
// Purpose: self-checking bench for vsfp_sequencer
// Assumes: latch-off count cut to 20 cycles
// Notes: inputs change on the falling edge
`timescale 1ns/10ps
`define CHK(n, e, v) begin total_checks++; if ((v) !== (e)) begin n_mismatch++; \
  $display("wrong value %s exp %0h seen %0h", n, e, v); end end
module vsfp_sequencer_test;
  localparam LAT = 20;
  logic clock_in = 0, srst_in = 1, en = 0, lsup = 0, ilo = 0, ihi = 0, uv = 0, ov = 0;
  logic cs = 0, dv = 0, shed = 0, ce = 1, deo, oe_n, rdy, ss, ocf, ovf, dw;
  logic [7:0] tgt = 8'h03, code;
  logic [2:0] pp = 3'h0, mid, low;
  logic [1:0] tot = 2'h3, sh = 2'h1, lim;
  logic [31:0] rs = 32'h0000_2561;
  int n_mismatch = 0, total_checks = 0, cyc = 0, k;
  vsfp_sequencer #(.OC_LATCH_CYCLES(13'h0014)) vsfp_sequencer_inst (.clock_in(clock_in),
    .srst_in(srst_in), .clk_en_in(ce), .enable_in(en), .driver_enable_in(dw),
    .current_limit_input_low_trip_in(ilo), .current_limit_input_high_trip_in(ihi), .undervolt_trip_in(uv),
    .overvolt_trip_in(ov), .current_sense_reference_overvolt_in(cs), .dynamic_voltage_id_transition_in(dv),
    .target_code_in(tgt), .phase_pulse_in(pp), .phase_total_in(tot), .phase_shed_in(sh),
    .shed_mode_in(shed), .driver_enable_out(deo), .driver_enable_oe_n_out(oe_n),
    .ref_code_out(code), .phase_mid_out(mid), .phase_low_out(low),
    .regulator_ready_out(rdy), .current_limit_phases_out(lim),
    .softstart_active_out(ss), .oc_fault_out(ocf), .ov_fault_out(ovf));
  vsfp_drv_model vsfp_drv_model_inst (.clock_in(clock_in), .low_supply_in(lsup),
    .drv_in(deo | oe_n), .drv_wire_out(dw));
  initial forever #5 clock_in = ~clock_in;
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clock_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      close_out();
    end
  end
  task automatic step(input int n);
    repeat (n) @(negedge clock_in);
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    xs = t ^ (t << 5);
  endfunction
  task automatic start(input logic [2:0] p);
    en = 0;
    step(4);
    rs = xs(rs);
    tgt = {4'h0, rs[3:0]} + 8'h02;
    sh = rs[5:4];
    pp = p;
    en = 1;
    step(12);
    `CHK("ss", 1'b1, ss)
    for (k = 0; k < 400 && rdy !== 1'b1; k++) step(1);
    pp = 3'h0;
    step(2);
    `CHK("code", tgt, code)
  endtask
  initial
  begin
    step(12);
    srst_in = 0;
    start(3'h5);
    `CHK("mid", 3'h2, mid)
    `CHK("drv", 1'b1, deo)
    `CHK("oe", 1'b0, oe_n)
    shed = 1;
    step(2);
    `CHK("limit", sh, lim)
    shed = 0;
    step(2);
    `CHK("limit", tot, lim)
    $display("test start done");
    ilo = 1;
    step(LAT / 2);
    ilo = 0;
    step(4);
    `CHK("oc early", 1'b0, ocf)
    ilo = 1;
    for (k = 0; k < 100 && ocf !== 1'b1; k++) step(1);
    `CHK("oc time", 1'b1, k >= LAT && k <= LAT + 4)
    `CHK("oc drv", 1'b0, deo)
    ilo = 0;
    step(20);
    `CHK("oc latch", 1'b1, ocf)
    $display("test oc done");
    start(3'h7);
    `CHK("oc clear", 1'b0, ocf)
    ihi = 1;
    step(4);
    ihi = 0;
    `CHK("oc now", 1'b1, ocf)
    start(3'h7);
    uv = 1;
    step(4);
    `CHK("ready", 1'b0, rdy)
    uv = 0;
    dv = 1;
    ov = 1;
    step(10);
    `CHK("ov mask", 1'b0, ovf)
    dv = 0;
    step(4);
    `CHK("ov", 1'b1, ovf)
    `CHK("low", 3'h7, low)
    ov = 0;
    for (k = 0; k < 300 && code !== 8'h00; k++) step(1);
    step(2);
    `CHK("ramp down", 8'h00, code)
    `CHK("hold low", 3'h7, low)
    `CHK("hold drv", 1'b1, deo)
    `CHK("ov latch", 1'b1, ovf)
    $display("test ov done");
    start(3'h7);
    cs = 1;
    step(4);
    cs = 0;
    `CHK("current_sense_reference", 1'b1, ovf)
    $display("test current_sense_reference done");
    start(3'h7);
    lsup = 1;
    step(3);
    `CHK("restart mid", 3'h7, mid)
    `CHK("restart drv", 1'b0, deo)
    step(1);
    lsup = 0;
    for (k = 0; k < 400 && rdy !== 1'b1; k++) step(1);
    `CHK("restart run", 1'b1, rdy)
    $display("test restart done");
    ce = 0;
    en = 0;
    step(6);
    `CHK("freeze", 1'b1, rdy)
    ce = 1;
    step(6);
    `CHK("off drv", 1'b0, deo)
    $display("test freeze done");
    close_out();
  end
endmodule
bind vsfp_sequencer vsfp_props vsfp_props_inst (.clock_in(clock_in), .srst_in(srst_in),
  .enable_in(enable_in), .undervolt_trip_in(undervolt_trip_in),
  .current_sense_reference_overvolt_in(current_sense_reference_overvolt_in), .phase_pulse_in(phase_pulse_in),
  .phase_shed_in(phase_shed_in), .shed_mode_in(shed_mode_in),
  .driver_enable_out(driver_enable_out), .ref_code_out(ref_code_out),
  .phase_mid_out(phase_mid_out), .phase_low_out(phase_low_out),
  .regulator_ready_out(regulator_ready_out),
  .current_limit_phases_out(current_limit_phases_out),
  .softstart_active_out(softstart_active_out), .oc_fault_out(oc_fault_out),
  .ov_fault_out(ov_fault_out));
